// ---- hw/vps_defines.vh ----
// constants of the pixel stream host controller
`ifndef VPS_DEFINES_VH
`define VPS_DEFINES_VH
// color pattern codes
`define VPS_PAT_PARALLEL 2'h0
`define VPS_PAT_SEQUENCE 2'h1
`define VPS_PAT_YCBCR    2'h2
// default stream parameters
`define VPS_FRAME_WIDTH  640
`define VPS_FRAME_HEIGHT 480
`define VPS_INTERLACED   0
`define VPS_BITS_PER_SMP 8
`define VPS_PATTERN      `VPS_PAT_PARALLEL
// samples of one pixel in sequential packing
`define VPS_SEQ_SAMPLES  3
// planes side by side in parallel and luma/chroma packing
`define VPS_PAR_PLANES   3
`define VPS_YCC_PLANES   2
// device pipeline delay in cycles, informative for the host
`define VPS_DEV_LATENCY  3
// beat width from pattern and sample width
`define VPS_DW(p, b) (((p) == `VPS_PAT_PARALLEL) ? `VPS_PAR_PLANES * (b) : \
                      (((p) == `VPS_PAT_YCBCR) ? `VPS_YCC_PLANES * (b) : (b)))
// buffer fill levels
`define VPS_BUF_EMPTY 2'h0
`define VPS_BUF_FULL  2'h2
`endif

// ---- hw/vps_fifo2.v ----
// two-entry flip-flop buffer with valid and ready on both sides
`include "vps_defines.vh"
module vps_fifo2 #(
  parameter DW = 24
) (
  input  wire          i_clk,    // clock
  input  wire          i_rst,    // synchronous reset
  input  wire          i_valid,  // write side valid
  output wire          o_ready,  // write side ready
  input  wire [DW-1:0] i_data,   // write data
  output wire          o_valid,  // read side valid
  input  wire          i_ready,  // read side ready
  output wire [DW-1:0] o_data,   // head entry
  output wire [1:0]    o_count   // fill level
);
  reg [DW-1:0] mem_reg [0:1];
  reg          rd_ptr_reg;
  reg          wr_ptr_reg;
  reg [1:0]    count_reg;
  wire         push;
  wire         pop;

  assign o_ready = (count_reg != `VPS_BUF_FULL);
  assign o_valid = (count_reg != `VPS_BUF_EMPTY);
  assign o_data  = mem_reg[rd_ptr_reg];
  assign o_count = count_reg;
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always @(posedge i_clk) begin
    if (i_rst) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg  <= `VPS_BUF_EMPTY;
    end else begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push & ~pop)
        count_reg <= count_reg + 2'h1;
      else if (pop & ~push)
        count_reg <= count_reg - 2'h1;
    end
  end

  // entries are only written, so data stays stable while no beat moves
  always @(posedge i_clk) begin
    if (i_rst) begin
      mem_reg[0] <= {DW{1'b0}};
      mem_reg[1] <= {DW{1'b0}};
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= i_data;
    end
  end
endmodule

// ---- hw/vps_pos_cnt.v ----
// pixel position tracker: sample, x and y of the next beat
`include "vps_defines.vh"
module vps_pos_cnt #(
  parameter WIDTH  = `VPS_FRAME_WIDTH,
  parameter HEIGHT = `VPS_FRAME_HEIGHT,
  parameter ILACE  = `VPS_INTERLACED,
  parameter SPP    = 1,
  parameter XW     = 12,
  parameter YW     = 11
) (
  input  wire          i_clk,   // clock
  input  wire          i_rst,   // synchronous reset
  input  wire          i_step,  // one beat moved
  output reg  [1:0]    o_smp,   // sample index within pixel
  output reg  [XW-1:0] o_x,     // column of next beat
  output reg  [YW-1:0] o_y,     // line of next beat
  output reg           o_field  // field of interlaced stream
);
  localparam integer  SMP_END  = SPP - 1;
  localparam integer  X_END    = WIDTH - 1;
  localparam integer  Y_END    = (ILACE ? HEIGHT / 2 : HEIGHT) - 1;
  localparam [1:0]    SMP_LAST = SMP_END[1:0];
  localparam [XW-1:0] X_LAST   = X_END[XW-1:0];
  localparam [YW-1:0] Y_LAST   = Y_END[YW-1:0];

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_smp   <= 2'h0;
      o_x     <= {XW{1'b0}};
      o_y     <= {YW{1'b0}};
      o_field <= 1'b0;
    end else if (i_step) begin
      if (o_smp != SMP_LAST) begin
        o_smp <= o_smp + 2'h1;
      end else begin
        o_smp <= 2'h0;
        if (o_x != X_LAST) begin
          o_x <= o_x + {{(XW-1){1'b0}}, 1'b1};
        end else begin
          o_x <= {XW{1'b0}};
          if (o_y != Y_LAST) begin
            o_y <= o_y + {{(YW-1){1'b0}}, 1'b1};
          end else begin
            o_y     <= {YW{1'b0}};
            o_field <= ILACE ? ~o_field : 1'b0;
          end
        end
      end
    end
  end
endmodule

// ---- hw/vps_host.v ----
// pixel stream host: feeds the device input port, drains its output port
`include "vps_defines.vh"
module vps_host #(
  parameter WIDTH   = `VPS_FRAME_WIDTH,
  parameter HEIGHT  = `VPS_FRAME_HEIGHT,
  parameter ILACE   = `VPS_INTERLACED,
  parameter BPS     = `VPS_BITS_PER_SMP,
  parameter PATTERN = `VPS_PATTERN,
  parameter XW      = 12,
  parameter YW      = 11
) (
  input  wire                                i_clk,        // clock, 50 MHz
  input  wire                                i_rst,        // synchronous reset
  // user side, pixels to send
  input  wire                                i_tx_valid,   // user beat offered
  output wire                                o_tx_ready,   // buffer takes beat
  input  wire [`VPS_DW(PATTERN, BPS)-1:0]    i_tx_data,    // user beat
  output wire [1:0]                          o_tx_smp,     // sample of next sent beat
  output wire [XW-1:0]                       o_tx_x,       // column of next sent beat
  output wire [YW-1:0]                       o_tx_y,       // line of next sent beat
  output wire                                o_tx_field,   // field of next sent beat
  // device input port
  output wire                                o_din_valid,  // beat to device
  input  wire                                i_din_ready,  // device ready
  output wire [`VPS_DW(PATTERN, BPS)-1:0]    o_din_data,   // beat data
  // device output port
  input  wire                                i_dout_valid, // beat from device
  output wire                                o_dout_ready, // host ready
  input  wire [`VPS_DW(PATTERN, BPS)-1:0]    i_dout_data,  // beat data
  // user side, received pixels
  output wire                                o_rx_valid,   // received beat present
  input  wire                                i_rx_ready,   // user takes beat
  output wire [`VPS_DW(PATTERN, BPS)-1:0]    o_rx_data,    // received beat
  output wire [1:0]                          o_rx_smp,     // sample of head beat
  output wire [XW-1:0]                       o_rx_x,       // column of head beat
  output wire [YW-1:0]                       o_rx_y,       // line of head beat
  output wire                                o_rx_field,   // field of head beat
  output wire                                o_rx_chroma   // 0 blue-diff, 1 red-diff
);
  localparam DW  = `VPS_DW(PATTERN, BPS);
  localparam SPP = (PATTERN == `VPS_PAT_SEQUENCE) ? `VPS_SEQ_SAMPLES : 1;

  // ************************************************************
  // transmit path
  // ************************************************************
  reg  din_rdy_q_reg;
  wire tx_buf_valid;
  wire din_beat;

  // the device's ready refers to the next cycle
  always @(posedge i_clk) begin
    if (i_rst)
      din_rdy_q_reg <= 1'b0;
    else
      din_rdy_q_reg <= i_din_ready;
  end

  // a beat may still go out the cycle after ready falls
  assign o_din_valid = tx_buf_valid & din_rdy_q_reg;
  assign din_beat    = o_din_valid;

  vps_fifo2 #(
    .DW(DW)
  ) u_tx_buf (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (i_tx_valid),
    .o_ready (o_tx_ready),
    .i_data  (i_tx_data),
    .o_valid (tx_buf_valid),
    .i_ready (din_rdy_q_reg),
    .o_data  (o_din_data),
    .o_count ()
  );

  vps_pos_cnt #(
    .WIDTH  (WIDTH),
    .HEIGHT (HEIGHT),
    .ILACE  (ILACE),
    .SPP    (SPP),
    .XW     (XW),
    .YW     (YW)
  ) u_tx_pos (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_step  (din_beat),
    .o_smp   (o_tx_smp),
    .o_x     (o_tx_x),
    .o_y     (o_tx_y),
    .o_field (o_tx_field)
  );

  // ************************************************************
  // receive path
  // ************************************************************
  reg        dout_rdy_q_reg;
  wire       dout_beat;
  wire       rx_pop;
  wire [1:0] rx_count;
  reg  [2:0] rx_count_next;

  // a device beat counts only if our ready was high the cycle before
  assign dout_beat = i_dout_valid & dout_rdy_q_reg;
  assign rx_pop    = o_rx_valid & i_rx_ready;

  always @* begin
    rx_count_next = {1'b0, rx_count} + {2'h0, dout_beat} - {2'h0, rx_pop};
  end

  // ready promises room for one beat next cycle, so a stalled user loses nothing
  assign o_dout_ready = ~i_rst & (rx_count_next < {1'b0, `VPS_BUF_FULL});

  always @(posedge i_clk) begin
    if (i_rst)
      dout_rdy_q_reg <= 1'b0;
    else
      dout_rdy_q_reg <= o_dout_ready;
  end

  vps_fifo2 #(
    .DW(DW)
  ) u_rx_buf (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (dout_beat),
    .o_ready (),
    .i_data  (i_dout_data),
    .o_valid (o_rx_valid),
    .i_ready (i_rx_ready),
    .o_data  (o_rx_data),
    .o_count (rx_count)
  );

  // positions follow the head of the receive buffer, in input order
  vps_pos_cnt #(
    .WIDTH  (WIDTH),
    .HEIGHT (HEIGHT),
    .ILACE  (ILACE),
    .SPP    (SPP),
    .XW     (XW),
    .YW     (YW)
  ) u_rx_pos (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_step  (rx_pop),
    .o_smp   (o_rx_smp),
    .o_x     (o_rx_x),
    .o_y     (o_rx_y),
    .o_field (o_rx_field)
  );

  // chroma alternates blue-difference then red-difference along a line
  assign o_rx_chroma = (PATTERN == `VPS_PAT_YCBCR) ? o_rx_x[0] : 1'b0;
endmodule

// ---- verification/vps_props.sv ----
// concurrent checks on the pixel stream host ports
`include "vps_defines.vh"
module vps_props #(
  parameter DW = 24
) (
  input wire logic          i_clk, i_rst, i_tx_valid, o_tx_ready, o_din_valid, i_din_ready,
  input wire logic          i_dout_valid, o_dout_ready, o_rx_valid, i_rx_ready,
  input wire logic [DW-1:0] o_din_data, o_rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_take;
    i_tx_valid && o_tx_ready && i_din_ready;
  endsequence
  sequence s_held;
    o_rx_valid && !i_rx_ready;
  endsequence
  a_din_gated: assert property (o_din_valid |-> $past(i_din_ready))
    else $error("beat sent without ready");
  a_take_to_din: assert property (s_take |=> o_din_valid)
    else $error("taken beat not offered");
  a_reset_quiet: assert property (disable iff (1'b0) i_rst ##1 i_rst |->
    !o_din_valid && !o_dout_ready) else $error("handshake active in reset");
  a_din_stable: assert property (!o_din_valid && !(i_tx_valid && o_tx_ready)
    |=> $stable(o_din_data)) else $error("idle data moved");
  a_rx_arrives: assert property (i_dout_valid && $past(o_dout_ready) |=> o_rx_valid)
    else $error("beat lost");
  a_rx_holds: assert property (s_held |=> o_rx_valid && $stable(o_rx_data))
    else $error("held beat changed");
  a_empty_ready: assert property (!o_rx_valid |-> o_dout_ready)
    else $error("empty buffer not ready");
  a_no_phantom: assert property (!o_rx_valid && !(i_dout_valid && $past(o_dout_ready))
    |=> !o_rx_valid) else $error("beat from nothing");
  a_tx_full_hold: assert property (!o_tx_ready && !o_din_valid |=> !o_tx_ready)
    else $error("full buffer freed");
endmodule
bind vps_host vps_props #(.DW(`VPS_DW(PATTERN, BPS))) u_props (.i_clk(i_clk),
  .i_rst(i_rst), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .o_din_valid(o_din_valid),
  .i_din_ready(i_din_ready), .i_dout_valid(i_dout_valid), .o_dout_ready(o_dout_ready),
  .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready), .o_din_data(o_din_data),
  .o_rx_data(o_rx_data));

// ---- verification/vps_dev_model.sv ----
// behavioural model of the streaming pixel device
module vps_dev_model (
  input  wire logic        i_clk, i_rst, i_gap, i_valid, i_ready,
  input  wire logic [23:0] i_data,
  output logic             o_ready, o_valid,
  output logic [23:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] q[$];
  int          t[$];
  int          cyc = 0;
  logic        rq = 0, aq = 0, go;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    rq <= i_ready;
    aq <= o_ready;
    if (i_rst) begin
      q.delete();
      t.delete();
      o_ready <= 0;
      o_valid <= 0;
      o_data <= 24'h5A5A5A;
    end else begin
      if (o_valid && rq) begin
        void'(q.pop_front());
        void'(t.pop_front());
      end
      if (i_valid && aq) begin
        q.push_back(i_data);
        t.push_back(cyc);
      end
      go = q.size() > 0 && cyc - t[0] >= 2 && i_ready;
      o_ready <= !i_gap && q.size() < 4;
      o_valid <= go;
      o_data <= go ? q[0] : o_data;
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// top testbench of the pixel stream host
`include "vps_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 0, i_rst = 1, tv = 0, rr = 0, gap = 0;
  logic        tr, dv, dr, uv, ur, rv, tf, rf, rc;
  logic        sv = 0, st, sdv, sdr, srv, sf, ydv, ydr, yrv, yf, yc;
  logic [1:0]  tsm, rsm, ssm, ysm;
  logic [7:0]  sdd, srd;
  logic [15:0] sd = 16'h0, ydd, yrd;
  logic [23:0] td = 24'h0, dd, ud, rd;
  logic [11:0] rx, tx, sx, yx;
  logic [10:0] ry, ty, sy, yy;
  int          err_count = 0, samples_checked = 0, n_tx = 0, n_rx = 0, n_din = 0;
  int          n_ls = 0, n_lr = 0;
  initial forever #10 i_clk = ~i_clk;
  vps_host #(.WIDTH(4), .HEIGHT(2)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_tx_valid(tv),
    .o_tx_ready(tr), .i_tx_data(td), .o_tx_smp(tsm), .o_tx_x(tx), .o_tx_y(ty), .o_tx_field(tf),
    .o_din_valid(dv), .i_din_ready(dr), .o_din_data(dd), .i_dout_valid(uv),
    .o_dout_ready(ur), .i_dout_data(ud), .o_rx_valid(rv), .i_rx_ready(rr), .o_rx_data(rd),
    .o_rx_smp(rsm), .o_rx_x(rx), .o_rx_y(ry), .o_rx_field(rf), .o_rx_chroma(rc));
  // loopback hosts cover sequential and luma/chroma packing with interlace
  vps_host #(.WIDTH(2), .HEIGHT(4), .ILACE(1), .PATTERN(`VPS_PAT_SEQUENCE)) u_dut_seq (
    .i_clk(i_clk), .i_rst(i_rst), .i_tx_valid(sv), .o_tx_ready(st), .i_tx_data(sd[7:0]),
    .o_tx_smp(), .o_tx_x(), .o_tx_y(), .o_tx_field(), .o_din_valid(sdv), .i_din_ready(sdr),
    .o_din_data(sdd), .i_dout_valid(sdv), .o_dout_ready(sdr), .i_dout_data(sdd),
    .o_rx_valid(srv), .i_rx_ready(rr), .o_rx_data(srd), .o_rx_smp(ssm), .o_rx_x(sx),
    .o_rx_y(sy), .o_rx_field(sf), .o_rx_chroma());
  vps_host #(.WIDTH(2), .HEIGHT(4), .ILACE(1), .PATTERN(`VPS_PAT_YCBCR)) u_dut_ycc (
    .i_clk(i_clk), .i_rst(i_rst), .i_tx_valid(sv), .o_tx_ready(), .i_tx_data(sd),
    .o_tx_smp(), .o_tx_x(), .o_tx_y(), .o_tx_field(), .o_din_valid(ydv), .i_din_ready(ydr),
    .o_din_data(ydd), .i_dout_valid(ydv), .o_dout_ready(ydr), .i_dout_data(ydd),
    .o_rx_valid(yrv), .i_rx_ready(rr), .o_rx_data(yrd), .o_rx_smp(ysm), .o_rx_x(yx),
    .o_rx_y(yy), .o_rx_field(yf), .o_rx_chroma(yc));
  vps_dev_model u_dev (.i_clk(i_clk), .i_rst(i_rst), .i_gap(gap), .i_valid(dv),
    .i_ready(ur), .i_data(dd), .o_ready(dr), .o_valid(uv), .o_data(ud));
  task check(input logic [23:0] s, input logic [23:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task results;
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task send(input int k);
    for (int i = 0; i < k; i++) begin
      td = 24'hA50000 + 24'(n_tx);
      tv = 1;
      do @(posedge i_clk); while (tr !== 1'b1);
      n_tx++;
      #1;
    end
    tv = 0;
  endtask
  task wait_rx(input int n);
    repeat (500) if (n_rx < n) begin
      @(posedge i_clk);
      #1;
    end
    check(24'(n_rx), 24'(n));
  endtask
  task t_loop;
    for (int i = 0; i < 24; i++) begin
      sd = 16'h3C00 + 16'(n_ls);
      sv = 1;
      do @(posedge i_clk); while (st !== 1'b1);
      n_ls++;
      #1;
    end
    sv = 0;
    repeat (100) if (n_lr < 24) begin
      @(posedge i_clk);
      #1;
    end
    check(24'(n_lr), 24'h18);
  endtask
  always @(posedge i_clk) if (!i_rst && dv === 1'b1) begin
    check(dd, 24'hA50000 + 24'(n_din));
    check(tx, 24'(n_din % 4));
    check(ty, 24'((n_din / 4) % 2));
    check({tsm, tf}, 3'h0);
    n_din++;
  end
  always @(posedge i_clk) if (!i_rst && srv === 1'b1 && rr) begin
    check(srd, 24'(n_lr));
    check(ssm, 24'(n_lr % 3));
    check(sx, 24'((n_lr / 3) % 2));
    check(sy, 24'((n_lr / 6) % 2));
    check(sf, 24'((n_lr / 12) % 2));
    check(yrv, 1'b1);
    check(yrd, 24'h3C00 + 24'(n_lr));
    check(yc, 24'(n_lr % 2));
    check(yx, 24'(n_lr % 2));
    check(yy, 24'((n_lr / 2) % 2));
    check(yf, 24'((n_lr / 4) % 2));
    check(ysm, 2'h0);
    n_lr++;
  end
  always @(posedge i_clk) if (!i_rst && rv === 1'b1 && rr) begin
    check(rd, 24'hA50000 + 24'(n_rx));
    check(rx, 24'(n_rx % 4));
    check(ry, 24'((n_rx / 4) % 2));
    check({rsm, rf, rc}, 4'h0);
    n_rx++;
  end
  task t_reset;
    #1;
    check(dv, 1'b0);
    check(ur, 1'b0);
    i_rst = 0;
    @(posedge i_clk);
    #1;
    check(tr, 1'b1);
    check(rv, 1'b0);
  endtask
  task t_stream;
    rr = 1;
    send(3);
    repeat (3) @(posedge i_clk);
    #1;
    send(5);
    wait_rx(8);
  endtask
  task t_stall;
    rr = 0;
    gap = 1;
    fork
      send(10);
      begin
        repeat (4) @(posedge i_clk);
        #1 gap = 0;
        repeat (40) @(posedge i_clk);
        #1;
        check(tr, 1'b0);
        check(ur, 1'b0);
        rr = 1;
      end
    join
    wait_rx(18);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    t_reset();
    t_stream();
    t_stall();
    t_loop();
    results();
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
